// ==== verilog/scic_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SCIC_MAP_SVH
`define SCIC_MAP_SVH

`define SCIC_ADDR_CONTROL 7'h02
`define SCIC_ADDR_SOFT_RESET 7'h07
`define SCIC_ADDR_EVENT_STATUS 7'h20
`define SCIC_ADDR_EVENT_IRQ_BLOCK 7'h21
`define SCIC_ADDR_LINE_CONTROL 7'h22
`define SCIC_ADDR_TX_QUEUE 7'h23
`define SCIC_ADDR_RX_QUEUE 7'h24
`define SCIC_ADDR_QUEUE_THRESHOLDS 7'h25
`define SCIC_ADDR_TALK_LIMIT_TIMEOUT 7'h27

`define SCIC_CONTROL_RESET 16'h8042
`define SCIC_CONTROL_WMASK 16'hf05f
`define SCIC_IRQ_BLOCK_RESET 16'h0024
`define SCIC_IRQ_BLOCK_WMASK 16'h7fff
`define SCIC_LIVE_MASK 16'h60ff
`define SCIC_BAD_READ_VALUE 32'h80000000

`define SCIC_CTL_WDT_SEL_HI 15
`define SCIC_CTL_WDT_SEL_LO 13
`define SCIC_CTL_WATCHDOG_ON 12
`define SCIC_CTL_REF_POWERDOWN 6
`define SCIC_CTL_CRC_ON 4
`define SCIC_CTL_IRQ_ACTIVE_SENSE 3
`define SCIC_CTL_IRQ_LEVEL 2
`define SCIC_CTL_OUT_FLOAT_ON_WRITE 1
`define SCIC_CTL_OUT_CLEAR_PER_FRAME 0

`define SCIC_ST_RESET_SEEN 15
`define SCIC_ST_WATCHDOG 9
`define SCIC_ST_CRC_ERROR 8
`define SCIC_SOFT_RESET_BIT 0

`define SCIC_CRC_POLY 8'h07
`define SCIC_CRC_INIT 8'h00

`define SCIC_CLK_PERIOD_NS 20
`define SCIC_MS_NS 1000000
`define SCIC_MS_CYC (`SCIC_MS_NS / `SCIC_CLK_PERIOD_NS)
`define SCIC_IRQ_PULSE_NS 1000
`define SCIC_IRQ_PULSE_CYC ((`SCIC_IRQ_PULSE_NS + `SCIC_CLK_PERIOD_NS - 1) / `SCIC_CLK_PERIOD_NS)

`endif

// ==== verilog/scic_pkg.sv ====
// Types shared by the serial port control logic
`default_nettype none
package scic_pkg;
    typedef logic [15:0] scic_word_t;
    typedef logic [6:0] scic_addr_t;
    typedef logic [12:0] scic_ms_t;
    typedef enum logic {SCIC_IRQ_EDGE, SCIC_IRQ_LEVEL} scic_irq_mode_t;
endpackage
`default_nettype wire

// ==== verilog/scic_crc8.sv ====
// Eight-bit frame check over a 24-bit frame body, most significant bit first
`default_nettype none
`include "scic_map.svh"
module scic_crc8 (
    // Frame body
    input wire logic [23:0] i_body,
    // Check byte
    output logic [7:0] o_crc
);
    always_comb begin
        logic [7:0] acc;
        acc = `SCIC_CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            if (acc[7] ^ i_body[i]) begin
                acc = {acc[6:0], 1'b0} ^ `SCIC_CRC_POLY;
            end else begin
                acc = {acc[6:0], 1'b0};
            end
        end
        o_crc = acc;
    end
endmodule
`default_nettype wire

// ==== verilog/scic_top.sv ====
// Serial port frame check, register map, watchdog and interrupt pin logic
//
// Contract
// - With check on, last eight frame bits are a CRC, poly x^8+x^2+x+1.
// - A write frame with a wrong check byte writes no register; it only sets the check-error status bit.
// - Bad-check reads return 0x80000000 and never pop the receive queue.
// - Control bit 2 picks pulse (0, default) or held level interrupt.
// - Control bit 3 sets interrupt pin polarity, reset zero.
// - Per-event block bit, bits 14-0 only (bit 15 not writable): one keeps event off the pin, status still records.
// - Level mode latches the pin until the status register is read.
// - Edge mode starts or restarts one pulse on any new unblocked event.
// - Control register resets to 0x8042.
// - Bits 15-13 pick watchdog period 50 ms to 5 s; bit 12 enables.
// - Frame check active only while control bit 4 is set.
// - Control bit 1 set floats the serial output during write frames.
// - Control bit 0 set clears serial output contents at frame start.
// - Interrupt pin governed by control fields and the block register.
// - Frame is read flag, 7-bit address, 16 data bits, then check byte.
// - Event bits sticky, cleared by writing one; live bits track conditions.
`default_nettype none
`include "scic_map.svh"
module scic_top
    import scic_pkg::*;
#(
    parameter int MS_CYC = `SCIC_MS_CYC,
    parameter int IRQ_PULSE_CYC = `SCIC_IRQ_PULSE_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Serial port pins
    input wire logic i_spi_clk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    // Interrupt pin
    output logic o_irq,
    // Modem events and live conditions
    input wire logic [15:0] i_event_pulse,
    input wire logic [15:0] i_live_state,
    // Queue datapath
    input wire logic [15:0] i_rx_data,
    output logic o_rx_pop,
    output logic o_tx_push,
    output logic [15:0] o_tx_data,
    output logic o_queue_flush,
    // Modem configuration
    output logic o_ref_powerdown,
    output logic [15:0] o_line_control,
    output logic [15:0] o_queue_thresholds,
    output logic [15:0] o_talk_limit_timeout
);
    logic rst_s1, rst_n;
    logic [2:0] sclk_s, cs_s;
    logic [1:0] sdi_s;
    logic [31:0] in_shift, out_shift, resp_reg;
    logic [4:0] bit_cnt;
    logic frame_is_write;
    scic_word_t ctrl_reg, block_reg, sticky_reg, status_prev_reg;
    logic soft_rst;
    logic irq_latch, irq_active;
    logic [7:0] pulse_cnt;
    logic [31:0] ms_div;
    scic_ms_t wdt_ms;
    logic wdt_hit;

    // Reset release through two flip-flops
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Pin synchronisers; third stage only for edge detection
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            sdi_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], i_spi_clk};
            cs_s <= {cs_s[1:0], i_spi_cs_n};
            sdi_s <= {sdi_s[0], i_spi_sdi};
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low;
    assign sclk_rise = sclk_s[1] && !sclk_s[2];
    assign sclk_fall = !sclk_s[1] && sclk_s[2];
    assign cs_fall = !cs_s[1] && cs_s[2];
    assign cs_rise = cs_s[1] && !cs_s[2];
    assign cs_low = !cs_s[1];

    // Frame decode; the last 24 or 32 bits are the frame
    logic crc_on, crc_ok, rw, frame_end;
    logic [23:0] body;
    logic [7:0] rx_crc, body_crc, resp_crc;
    scic_addr_t addr;
    scic_word_t wdata, rdata, status_now;
    assign crc_on = ctrl_reg[`SCIC_CTL_CRC_ON];
    assign body = crc_on ? in_shift[31:8] : in_shift[23:0];
    assign rx_crc = in_shift[7:0];
    assign rw = body[23];
    assign addr = body[22:16];
    assign wdata = body[15:0];
    assign frame_end = cs_rise;
    assign crc_ok = !crc_on || (body_crc == rx_crc);

    scic_crc8 u_check (
        .i_body(body),
        .o_crc(body_crc)
    );
    scic_crc8 u_answer (
        .i_body({body[23:16], rdata}),
        .o_crc(resp_crc)
    );

    logic wr_ok, rd_ok;
    assign wr_ok = frame_end && !rw && crc_ok;
    assign rd_ok = frame_end && rw && crc_ok;
    assign soft_rst = wr_ok && addr == `SCIC_ADDR_SOFT_RESET && wdata[`SCIC_SOFT_RESET_BIT];

    function automatic logic hit(input scic_addr_t a, input scic_addr_t target);
        hit = (a == target);
    endfunction

    // live bits track conditions, others are sticky
    assign status_now = (sticky_reg & ~`SCIC_LIVE_MASK) | (i_live_state & `SCIC_LIVE_MASK);

    always_comb begin
        if (hit(addr, `SCIC_ADDR_CONTROL)) begin
            rdata = ctrl_reg;
        end else if (hit(addr, `SCIC_ADDR_EVENT_STATUS)) begin
            rdata = status_now;
        end else if (hit(addr, `SCIC_ADDR_EVENT_IRQ_BLOCK)) begin
            rdata = block_reg;
        end else if (hit(addr, `SCIC_ADDR_LINE_CONTROL)) begin
            rdata = o_line_control;
        end else if (hit(addr, `SCIC_ADDR_RX_QUEUE)) begin
            rdata = i_rx_data;
        end else if (hit(addr, `SCIC_ADDR_QUEUE_THRESHOLDS)) begin
            rdata = o_queue_thresholds;
        end else if (hit(addr, `SCIC_ADDR_TALK_LIMIT_TIMEOUT)) begin
            rdata = o_talk_limit_timeout;
        end else begin
            rdata = 16'h0000;
        end
    end

    // Input shift on falling serial clock, frame kind from first bit
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_shift <= 32'h0;
            bit_cnt <= 5'h0;
            frame_is_write <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt <= 5'h0;
            frame_is_write <= 1'b0;
        end else if (cs_low && sclk_fall) begin
            in_shift <= {in_shift[30:0], sdi_s[1]};
            if (bit_cnt == 5'h0) begin
                frame_is_write <= !sdi_s[1];
            end
            if (bit_cnt != 5'h1f) begin
                bit_cnt <= bit_cnt + 5'h1;
            end
        end
    end

    // Answer for the next frame
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_reg <= 32'h0;
        end else if (frame_end) begin
            if (rw && !crc_ok) begin
                resp_reg <= `SCIC_BAD_READ_VALUE;
            end else if (rw) begin
                resp_reg <= crc_on ? {body[23:16], rdata, resp_crc} : {body[23:16], rdata, 8'h00};
            end else begin
                resp_reg <= crc_on ? in_shift : {body, 8'h00};
            end
        end
    end

    // Output shift, launched on rising serial clock
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_shift <= 32'h0;
            o_spi_sdo <= 1'b0;
        end else if (cs_fall) begin
            out_shift <= ctrl_reg[`SCIC_CTL_OUT_CLEAR_PER_FRAME] ? 32'h0 : resp_reg;
        end else if (cs_low && sclk_rise) begin
            o_spi_sdo <= out_shift[31];
            out_shift <= {out_shift[30:0], 1'b0};
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_spi_sdo_oe <= 1'b0;
        end else begin
            o_spi_sdo_oe <= cs_low && !(ctrl_reg[`SCIC_CTL_OUT_FLOAT_ON_WRITE] &&
                                        bit_cnt != 5'h0 && frame_is_write);
        end
    end

    // Control and plain registers; writes only with good check
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `SCIC_CONTROL_RESET;
            block_reg <= `SCIC_IRQ_BLOCK_RESET;
            o_line_control <= 16'h0;
            o_queue_thresholds <= 16'h0;
            o_talk_limit_timeout <= 16'h0;
        end else if (soft_rst) begin
            ctrl_reg <= `SCIC_CONTROL_RESET;
            block_reg <= `SCIC_IRQ_BLOCK_RESET;
            o_line_control <= 16'h0;
            o_queue_thresholds <= 16'h0;
            o_talk_limit_timeout <= 16'h0;
        end else if (wr_ok) begin
            if (hit(addr, `SCIC_ADDR_CONTROL)) begin
                ctrl_reg <= wdata & `SCIC_CONTROL_WMASK;
            end else if (hit(addr, `SCIC_ADDR_EVENT_IRQ_BLOCK)) begin
                block_reg <= wdata & `SCIC_IRQ_BLOCK_WMASK;
            end else if (hit(addr, `SCIC_ADDR_LINE_CONTROL)) begin
                o_line_control <= wdata;
            end else if (hit(addr, `SCIC_ADDR_QUEUE_THRESHOLDS)) begin
                o_queue_thresholds <= wdata;
            end else if (hit(addr, `SCIC_ADDR_TALK_LIMIT_TIMEOUT)) begin
                o_talk_limit_timeout <= wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ref_powerdown <= 1'b1;
        end else begin
            o_ref_powerdown <= ctrl_reg[`SCIC_CTL_REF_POWERDOWN];
        end
    end

    // Queue strobes; no pop on a bad read
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rx_pop <= 1'b0;
            o_tx_push <= 1'b0;
            o_tx_data <= 16'h0;
            o_queue_flush <= 1'b0;
        end else begin
            o_rx_pop <= rd_ok && hit(addr, `SCIC_ADDR_RX_QUEUE);
            o_tx_push <= wr_ok && hit(addr, `SCIC_ADDR_TX_QUEUE);
            o_queue_flush <= soft_rst;
            if (wr_ok && hit(addr, `SCIC_ADDR_TX_QUEUE)) begin
                o_tx_data <= wdata;
            end
        end
    end

    function automatic scic_ms_t wdt_limit(input logic [2:0] sel);
        case (sel)
            3'h0: wdt_limit = 13'd50;
            3'h1: wdt_limit = 13'd100;
            3'h2: wdt_limit = 13'd500;
            3'h3: wdt_limit = 13'd1000;
            3'h4: wdt_limit = 13'd2000;
            3'h5: wdt_limit = 13'd3000;
            3'h6: wdt_limit = 13'd4000;
            default: wdt_limit = 13'd5000;
        endcase
    endfunction

    // watchdog, restarted by every good frame
    logic wdt_on, ms_tick;
    assign wdt_on = ctrl_reg[`SCIC_CTL_WATCHDOG_ON];
    assign ms_tick = (ms_div == 32'(MS_CYC - 1));
    assign wdt_hit = wdt_on && ms_tick &&
                     (wdt_ms + 13'h1 >= wdt_limit(ctrl_reg[`SCIC_CTL_WDT_SEL_HI:`SCIC_CTL_WDT_SEL_LO]));
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_div <= 32'h0;
            wdt_ms <= 13'h0;
        end else if (!wdt_on || (frame_end && crc_ok)) begin
            ms_div <= 32'h0;
            wdt_ms <= 13'h0;
        end else if (ms_tick) begin
            ms_div <= 32'h0;
            wdt_ms <= wdt_hit ? 13'h0 : wdt_ms + 13'h1;
        end else begin
            ms_div <= ms_div + 32'h1;
        end
    end

    // sticky status, set wins over write-one-to-clear
    scic_word_t set_bits, clr_bits;
    always_comb begin
        set_bits = i_event_pulse;
        set_bits[`SCIC_ST_WATCHDOG] = i_event_pulse[`SCIC_ST_WATCHDOG] | wdt_hit;
        set_bits[`SCIC_ST_CRC_ERROR] = i_event_pulse[`SCIC_ST_CRC_ERROR] | (frame_end && !crc_ok);
        set_bits[`SCIC_ST_RESET_SEEN] = i_event_pulse[`SCIC_ST_RESET_SEEN] | soft_rst;
        clr_bits = (wr_ok && hit(addr, `SCIC_ADDR_EVENT_STATUS)) ? wdata : 16'h0;
    end
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sticky_reg <= 16'h0;
        end else begin
            sticky_reg <= ((sticky_reg & ~clr_bits) | set_bits) & ~`SCIC_LIVE_MASK;
        end
    end

    // new events gated by block bits
    scic_word_t new_evt;
    logic irq_evt, stat_rd;
    assign new_evt = status_now & ~status_prev_reg;
    assign irq_evt = |(new_evt & ~block_reg);
    assign stat_rd = rd_ok && hit(addr, `SCIC_ADDR_EVENT_STATUS);
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_prev_reg <= 16'h0;
        end else begin
            status_prev_reg <= status_now;
        end
    end

    // level latch, new event wins over the read
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_latch <= 1'b0;
        end else if (soft_rst) begin
            irq_latch <= 1'b0;
        end else if (irq_evt) begin
            irq_latch <= 1'b1;
        end else if (stat_rd) begin
            irq_latch <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= 8'h0;
        end else if (irq_evt) begin
            pulse_cnt <= 8'(IRQ_PULSE_CYC);
        end else if (pulse_cnt != 8'h0) begin
            pulse_cnt <= pulse_cnt - 8'h1;
        end
    end

    // mode and polarity select the pin
    scic_irq_mode_t irq_mode;
    assign irq_mode = ctrl_reg[`SCIC_CTL_IRQ_LEVEL] ? SCIC_IRQ_LEVEL : SCIC_IRQ_EDGE;
    assign irq_active = (irq_mode == SCIC_IRQ_LEVEL) ? irq_latch : (pulse_cnt != 8'h0);
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_active ^ ctrl_reg[`SCIC_CTL_IRQ_ACTIVE_SENSE];
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    a_bad_write_held: assert property (
        frame_end && crc_on && !crc_ok && !rw |=> ctrl_reg == $past(ctrl_reg) && !o_tx_push)
        else $error("bad-check write changed state");
    a_bad_read_value: assert property (
        frame_end && rw && !crc_ok |=> resp_reg == `SCIC_BAD_READ_VALUE && !o_rx_pop)
        else $error("bad-check read answer wrong or popped");
    a_check_gated: assert property (
        frame_end && !crc_on && !rw && addr == `SCIC_ADDR_LINE_CONTROL |=>
        o_line_control == $past(wdata))
        else $error("check applied while disabled");
    a_level_latch: assert property (
        irq_evt ##1 (irq_mode == SCIC_IRQ_LEVEL && !stat_rd && !soft_rst)[*3] |->
        o_irq == !ctrl_reg[`SCIC_CTL_IRQ_ACTIVE_SENSE])
        else $error("level interrupt not held");
    a_edge_pulse: assert property (
        irq_mode == SCIC_IRQ_EDGE && irq_evt |=> ##1 o_irq != ctrl_reg[`SCIC_CTL_IRQ_ACTIVE_SENSE])
        else $error("edge pulse missing");
    a_block_event: assert property (
        new_evt != 16'h0 && (new_evt & ~block_reg) == 16'h0 && !irq_latch |=> !irq_latch)
        else $error("blocked event reached the pin");
    a_pin_sense: assert property (
        o_irq == ($past(irq_active) ^ $past(ctrl_reg[`SCIC_CTL_IRQ_ACTIVE_SENSE])))
        else $error("interrupt polarity wrong");
    a_soft_reset_val: assert property (
        soft_rst |=> ctrl_reg == `SCIC_CONTROL_RESET && sticky_reg[`SCIC_ST_RESET_SEEN])
        else $error("control not restored by reset");
    a_frame_clear: assert property (
        cs_fall && ctrl_reg[`SCIC_CTL_OUT_CLEAR_PER_FRAME] |=> out_shift == 32'h0)
        else $error("output not cleared at frame start");
    a_float_write: assert property (
        ctrl_reg[`SCIC_CTL_OUT_FLOAT_ON_WRITE] && cs_low && frame_is_write && bit_cnt != 5'h0
        |=> !o_spi_sdo_oe)
        else $error("output driven during write frame");
    a_watchdog_flag: assert property (
        wdt_hit |=> sticky_reg[`SCIC_ST_WATCHDOG])
        else $error("watchdog expiry not recorded");
endmodule
`default_nettype wire

// ==== test/scic_host.sv ====
// Host serial master model that clocks frames through the port
`default_nettype none
module scic_host #(
    parameter int HALF = 6
) (
    // Clock
    input wire logic i_clk,
    // Serial pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_sdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic oe_seen;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
        oe_seen = 1'b0;
    end
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = '0;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (HALF) @(posedge i_clk);
        for (int k = n - 1; k >= 0; k--) begin
            o_sclk <= 1'b1;
            o_sdi <= w[k];
            repeat (HALF) @(posedge i_clk);
            // Floating output reads as the inverse of the level the port last drove
            r = {r[30:0], i_sdo_oe ? i_sdo : ~i_sdo};
            oe_seen = i_sdo_oe;
            o_sclk <= 1'b0;
            repeat (HALF) @(posedge i_clk);
        end
        o_cs_n <= 1'b1;
        // Released data line shows a changed level
        o_sdi <= ~o_sdi;
        repeat (10) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ==== test/scic_top_bench.sv ====
// Self-checking bench for the serial port control logic
`default_nettype none
`include "scic_map.svh"
module scic_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 40;
    localparam int PULSE = 8;
    logic clk, rst_n, sclk, cs_n, sdi, sdo, oe, irq, pop, push, flush, pd, crc_on;
    logic [15:0] ev, live, rx, txd, lc, qt, tl;
    int err_count, tests_run, pops, pushes, flushes, cyc;
    scic_top #(.MS_CYC(MS), .IRQ_PULSE_CYC(PULSE)) scic_top_i (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_spi_clk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .o_irq(irq),
        .i_event_pulse(ev), .i_live_state(live), .i_rx_data(rx), .o_rx_pop(pop),
        .o_tx_push(push), .o_tx_data(txd), .o_queue_flush(flush),
        .o_ref_powerdown(pd), .o_line_control(lc), .o_queue_thresholds(qt),
        .o_talk_limit_timeout(tl));
    scic_host scic_host_i (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
        .i_sdo(sdo), .i_sdo_oe(oe));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        pops += int'(pop);
        pushes += int'(push);
        flushes += int'(flush);
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h want %h", $time, s, seen, exp);
        end
    endtask
    // zero start, poly 0x07, no final inversion
    function automatic logic [7:0] crc8(input logic [23:0] b);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 23; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[k]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic frame(input logic rw, input logic [6:0] a, input logic [15:0] d,
                         input logic bad, output logic [31:0] r);
        logic [23:0] b;
        b = {rw, a, d};
        if (crc_on) scic_host_i.xfer({b, crc8(b) ^ {7'h00, bad}}, 32, r);
        else scic_host_i.xfer({8'h00, b}, 24, r);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [31:0] r;
        frame(1'b0, a, d, 1'b0, r);
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        logic [31:0] r;
        frame(1'b1, a, 16'h0000, 1'b0, r);
        frame(1'b1, `SCIC_ADDR_CONTROL, 16'h0000, 1'b0, r);
        d = crc_on ? r[23:8] : r[15:0];
        if (crc_on) check(32'(r[7:0]), 32'(crc8(r[31:8])), "answer crc");
    endtask
    task automatic kick(input int n);
        @(posedge clk);
        ev[n] <= 1'b1;
        @(posedge clk);
        ev <= '0;
    endtask
    task automatic t_reset;
        logic [15:0] d;
        rd(`SCIC_ADDR_CONTROL, d);
        check(32'(d), 32'h8042, "control reset");
        rd(`SCIC_ADDR_EVENT_IRQ_BLOCK, d);
        check(32'(d), 32'h0024, "block reset");
        rd(7'h10, d);
        check(32'(d), 32'h0, "unmapped read");
        check(32'(pd), 32'h1, "powerdown reset");
        $display("test reset done");
    endtask
    task automatic t_regs;
        logic [15:0] d;
        wr(`SCIC_ADDR_TX_QUEUE, 16'ha5c3);
        check(32'(pushes), 32'h1, "push count");
        check(32'(txd), 32'ha5c3, "push data");
        wr(`SCIC_ADDR_LINE_CONTROL, 16'h1357);
        check(32'(lc), 32'h1357, "line control");
        check(32'(scic_host_i.oe_seen), 32'h0, "float on write");
        wr(`SCIC_ADDR_CONTROL, 16'h8040);
        wr(`SCIC_ADDR_QUEUE_THRESHOLDS, 16'h0042);
        check(32'(scic_host_i.oe_seen), 32'h1, "driven on write");
        check(32'(qt), 32'h0042, "thresholds");
        wr(`SCIC_ADDR_TALK_LIMIT_TIMEOUT, 16'h00a5);
        check(32'(tl), 32'h00a5, "talk limit");
        check(32'(pd), 32'h1, "powerdown kept");
        wr(`SCIC_ADDR_CONTROL, 16'h8043);
        rd(`SCIC_ADDR_CONTROL, d);
        check(32'(d), 32'h0, "cleared output");
        wr(`SCIC_ADDR_CONTROL, 16'h8042);
        $display("test regs done");
    endtask
    task automatic t_irq;
        int hi;
        logic [15:0] d;
        kick(10);
        hi = 0;
        repeat (40) @(posedge clk) hi += int'(irq === 1'b1);
        check(32'(hi), 32'(PULSE), "edge pulse length");
        wr(`SCIC_ADDR_EVENT_IRQ_BLOCK, 16'h0824);
        kick(11);
        hi = 0;
        repeat (40) @(posedge clk) hi += int'(irq === 1'b1);
        check(32'(hi), 32'h0, "blocked event");
        live <= 16'h0080;
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(d & 16'h0c80), 32'h0c80, "status recorded");
        live <= 16'h0000;
        wr(`SCIC_ADDR_EVENT_STATUS, 16'h0c00);
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(d & 16'h0c80), 32'h0, "status cleared");
        wr(`SCIC_ADDR_CONTROL, 16'h804e);
        check(32'(irq), 32'h1, "inverted idle");
        kick(10);
        repeat (30) @(posedge clk);
        check(32'(irq), 32'h0, "level held");
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(irq), 32'h1, "level released");
        wr(`SCIC_ADDR_EVENT_STATUS, 16'h0400);
        wr(`SCIC_ADDR_CONTROL, 16'h8042);
        $display("test irq done");
    endtask
    task automatic t_crc;
        logic [31:0] r;
        logic [15:0] d;
        int p0;
        wr(`SCIC_ADDR_CONTROL, 16'h8052);
        crc_on = 1'b1;
        rd(`SCIC_ADDR_CONTROL, d);
        check(32'(d), 32'h8052, "check on");
        frame(1'b0, `SCIC_ADDR_LINE_CONTROL, 16'hffff, 1'b1, r);
        check(32'(lc), 32'h1357, "bad write ignored");
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(d[8]), 32'h1, "bad frame flagged");
        p0 = pops;
        frame(1'b1, `SCIC_ADDR_RX_QUEUE, 16'h0000, 1'b1, r);
        frame(1'b1, `SCIC_ADDR_CONTROL, 16'h0000, 1'b0, r);
        check(r, `SCIC_BAD_READ_VALUE, "bad read answer");
        check(32'(pops - p0), 32'h0, "no pop");
        rd(`SCIC_ADDR_RX_QUEUE, d);
        check(32'(d), 32'(rx), "queue data");
        check(32'(pops - p0), 32'h1, "one pop");
        wr(`SCIC_ADDR_CONTROL, 16'h8042);
        crc_on = 1'b0;
        $display("test crc done");
    endtask
    task automatic t_wdt;
        logic [15:0] d;
        wr(`SCIC_ADDR_EVENT_STATUS, 16'h0100);
        wr(`SCIC_ADDR_CONTROL, 16'h1042);
        repeat (40 * MS) @(posedge clk);
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(d[9]), 32'h0, "watchdog early");
        repeat (58 * MS) @(posedge clk);
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(d[9]), 32'h1, "watchdog expired");
        $display("test watchdog done");
    endtask
    task automatic t_soft;
        logic [15:0] d;
        wr(`SCIC_ADDR_SOFT_RESET, 16'h0001);
        check(32'(flushes), 32'h1, "flush pulse");
        rd(`SCIC_ADDR_CONTROL, d);
        check(32'(d), 32'h8042, "soft defaults");
        check(32'(tl), 32'h0, "soft talk limit");
        rd(`SCIC_ADDR_EVENT_STATUS, d);
        check(32'(d[15]), 32'h1, "reset seen");
        $display("test soft reset done");
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ev = '0;
        live = '0;
        rx = 16'hbeef;
        crc_on = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_regs();
        t_irq();
        t_crc();
        t_wdt();
        t_soft();
        wrap_up();
    end
endmodule
`default_nettype wire
